// ===== hw/error_function_config_header.sv
// configuration bank of the error-reporting function with first and next
// global error logs, serr generation and an interrupt output
// assumes an apb3 master on clk_sys and error pulses synchronous to clk_sys
`timescale 1ns/1ps

module error_function_config_header #(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              warm_reset,
    input  wire logic              ce,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // error events, one-cycle pulses
    input  wire logic              err_dram,
    input  wire logic              err_primary_hub_link,
    input  wire logic              err_processor_system_bus,
    input  wire logic              err_second_hub_link,
    input  wire logic              err_third_hub_link,
    input  wire logic              err_fourth_hub_link,
    // strap: high selects the multi-function header value
    input  wire logic              multi_function_strap,
    // system error and interrupt
    output logic                   serr_pulse,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////
    // parameter check

    // the decoder reads the bits above 9, so at least one must exist
    if (ADDR_W < 11 || ADDR_W > 32)
    begin : g_bad_addr
        $error("ADDR_W must lie between 11 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // register select

    typedef enum logic [3:0] {
        SEL_NONE      = 4'b0000,
        SEL_COMMAND   = 4'b0001,
        SEL_STATUS    = 4'b0010,
        SEL_SUBCLASS  = 4'b0011,
        SEL_BASECLASS = 4'b0100,
        SEL_LATENCY   = 4'b0101,
        SEL_HEADER    = 4'b0110,
        SEL_VENDOR    = 4'b0111,
        SEL_SUBSYS    = 4'b1000,
        SEL_FIRST     = 4'b1001,
        SEL_NEXT      = 4'b1010,
        SEL_SIGEN     = 4'b1011,
        SEL_IRQ_STAT  = 4'b1100,
        SEL_IRQ_EN    = 4'b1101,
        SEL_IRQ_CLR   = 4'b1110
    } reg_sel_t;

    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        reg_sel_t   sel;
        idx = addr[9:2];
        sel = SEL_NONE;
        if (addr[1:0] == 2'b00 && addr[ADDR_W-1:10] == '0)
        begin
            unique case (idx)
                errcfg_pkg::IDX_COMMAND:    sel = SEL_COMMAND;
                errcfg_pkg::IDX_STATUS:     sel = SEL_STATUS;
                errcfg_pkg::IDX_SUBCLASS:   sel = SEL_SUBCLASS;
                errcfg_pkg::IDX_BASECLASS:  sel = SEL_BASECLASS;
                errcfg_pkg::IDX_LATENCY:    sel = SEL_LATENCY;
                errcfg_pkg::IDX_HEADER:     sel = SEL_HEADER;
                errcfg_pkg::IDX_BOARD_VEND: sel = SEL_VENDOR;
                errcfg_pkg::IDX_BOARD_SUBS: sel = SEL_SUBSYS;
                errcfg_pkg::IDX_FIRST_ERR:  sel = SEL_FIRST;
                errcfg_pkg::IDX_NEXT_ERR:   sel = SEL_NEXT;
                errcfg_pkg::IDX_SIG_ENABLE: sel = SEL_SIGEN;
                errcfg_pkg::IDX_IRQ_STATUS: sel = SEL_IRQ_STAT;
                errcfg_pkg::IDX_IRQ_ENABLE: sel = SEL_IRQ_EN;
                errcfg_pkg::IDX_IRQ_CLEAR:  sel = SEL_IRQ_CLR;
                default:                    sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [31:0]                 first_log;
        logic [31:0]                 next_log;
        logic [31:0]                 sig_enable;
        logic                        serr_enable;
        logic                        signaled_system_error_flag;
        logic [15:0]                 vendor_ident;
        logic                        vendor_locked;
        logic [15:0]                 subsys_ident;
        logic                        subsys_locked;
        logic                        header_multi;
        logic [errcfg_pkg::IRQ_W-1:0] irq_status;
        logic [errcfg_pkg::IRQ_W-1:0] irq_enable;
        logic                        serr;
        logic                        irq;
        logic                        ready;
        logic [31:0]                 rdata;
        logic                        slverr;
    } state_t;

    localparam state_t STATE_RESET = '{
        first_log:     errcfg_pkg::ERR_LOG_RESET,
        next_log:      errcfg_pkg::ERR_LOG_RESET,
        sig_enable:    '0,
        serr_enable:   1'b0,
        signaled_system_error_flag:           1'b0,
        vendor_ident:  errcfg_pkg::IDENT_RESET,
        vendor_locked: 1'b0,
        subsys_ident:  errcfg_pkg::IDENT_RESET,
        subsys_locked: 1'b0,
        header_multi:  1'b0,
        irq_status:    '0,
        irq_enable:    '0,
        serr:          1'b0,
        irq:           1'b0,
        ready:         1'b0,
        rdata:         '0,
        slverr:        1'b0
    };

    state_t   state_reg;
    state_t   state_next;

    reg_sel_t sel;
    logic     wr_done;
    logic     rd_prep;
    logic [31:0] events;
    logic [31:0] first_keep;
    logic [31:0] next_keep;
    logic [31:0] next_block;
    logic [31:0] rise;
    logic [31:0] wclr;
    logic [errcfg_pkg::IRQ_W-1:0] irq_set;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_next = state_reg;
        sel        = decode(paddr);
        // write lands at the edge that completes the access
        wr_done    = psel && penable && state_reg.ready && pwrite;
        rd_prep    = psel && penable && !state_reg.ready;
        wclr       = '0;
        next_block = '0;
        irq_set    = '0;
        rd_word    = '0;

        // warm reset clears the plain registers, logs and irq status are kept
        if (warm_reset)
        begin
            state_next            = STATE_RESET;
            state_next.first_log  = state_reg.first_log;
            state_next.next_log   = state_reg.next_log;
            state_next.irq_status = state_reg.irq_status;
        end

        // event vector in log layout
        events = '0;
        events[errcfg_pkg::BIT_DRAM]    = err_dram;
        events[errcfg_pkg::BIT_PRIMARY] = err_primary_hub_link;
        events[errcfg_pkg::BIT_SYSBUS]  = err_processor_system_bus;
        events[errcfg_pkg::BIT_FOURTH]  = err_fourth_hub_link;
        events[errcfg_pkg::BIT_THIRD]   = err_third_hub_link;
        events[errcfg_pkg::BIT_SECOND]  = err_second_hub_link;

        // write-one-to-clear on the logs
        if (wr_done && sel == SEL_FIRST)
        begin
            wclr = pwdata & errcfg_pkg::ERR_LOG_MASK;
        end
        first_keep = state_reg.first_log & ~wclr;
        wclr = '0;
        if (wr_done && sel == SEL_NEXT)
        begin
            wclr = pwdata & errcfg_pkg::ERR_LOG_MASK;
        end
        next_keep = state_reg.next_log & ~wclr;

        // first log fills only while empty, set beats clear
        if (first_keep == '0)
        begin
            state_next.first_log = events;
            state_next.next_log  = next_keep;
        end
        else
        begin
            // later errors go to the next log minus blocked bits
            next_block = first_keep;
            if ((first_keep & errcfg_pkg::ERR_GROUP_MASK) != '0)
            begin
                next_block = next_block | errcfg_pkg::ERR_GROUP_MASK;
            end
            state_next.first_log = first_keep;
            state_next.next_log  = next_keep | (events & ~next_block);
        end

        // serr on a 0-to-1 transition of a flag set in sig_enable, while serr_enable is set
        rise = (state_next.first_log & ~state_reg.first_log)
             | (state_next.next_log & ~state_reg.next_log);
        state_next.serr = 1'b0;
        if (((rise & state_reg.sig_enable) != '0) && state_reg.serr_enable)
        begin
            state_next.serr = 1'b1;
        end

        // signaled system error flag, set beats clear
        if (wr_done && sel == SEL_STATUS && pwdata[errcfg_pkg::BIT_SSE])
        begin
            state_next.signaled_system_error_flag = 1'b0;
        end
        if (state_next.serr)
        begin
            state_next.signaled_system_error_flag = 1'b1;
        end

        // software-written controls, read-only fields ignored
        if (wr_done)
        begin
            unique case (sel)
                SEL_COMMAND:
                    state_next.serr_enable =
                        pwdata[errcfg_pkg::BIT_SERR_EN];
                SEL_SIGEN:
                    state_next.sig_enable =
                        pwdata & errcfg_pkg::ERR_LOG_MASK;
                SEL_IRQ_EN:
                    state_next.irq_enable = pwdata[errcfg_pkg::IRQ_W-1:0];
                SEL_VENDOR:
                    if (!state_reg.vendor_locked)
                    begin
                        state_next.vendor_ident  = pwdata[15:0];
                        state_next.vendor_locked = 1'b1;
                    end
                SEL_SUBSYS:
                    if (!state_reg.subsys_locked)
                    begin
                        state_next.subsys_ident  = pwdata[15:0];
                        state_next.subsys_locked = 1'b1;
                    end
                default:
                    state_next.serr_enable = state_next.serr_enable;
            endcase
        end

        // interrupt sources, set beats clear
        irq_set[errcfg_pkg::IRQ_FIRST] =
            (state_next.first_log & ~state_reg.first_log) != '0;
        irq_set[errcfg_pkg::IRQ_NEXT] =
            (state_next.next_log & ~state_reg.next_log) != '0;
        irq_set[errcfg_pkg::IRQ_SERR] = state_next.serr;
        if (wr_done && sel == SEL_IRQ_CLR)
        begin
            state_next.irq_status =
                state_next.irq_status & ~pwdata[errcfg_pkg::IRQ_W-1:0];
        end
        state_next.irq_status = state_next.irq_status | irq_set;
        state_next.irq =
            (state_next.irq_status & state_next.irq_enable) != '0;

        // strap level caught by the clock
        state_next.header_multi = multi_function_strap;

        // read word, reserved bits zero
        unique case (sel)
            SEL_COMMAND:
                rd_word[errcfg_pkg::BIT_SERR_EN] = state_reg.serr_enable;
            SEL_STATUS:
                rd_word[errcfg_pkg::BIT_SSE] = state_reg.signaled_system_error_flag;
            SEL_SUBCLASS:
                rd_word[7:0] = errcfg_pkg::SUBCLASS_VAL;
            SEL_BASECLASS:
                rd_word[7:0] = errcfg_pkg::BASECLASS_VAL;
            SEL_LATENCY:
                rd_word[7:0] = errcfg_pkg::LATENCY_VAL;
            SEL_HEADER:
                rd_word[7:0] = state_reg.header_multi
                             ? errcfg_pkg::HEADER_MULTI
                             : errcfg_pkg::HEADER_SINGLE;
            SEL_VENDOR:
                rd_word[15:0] = state_reg.vendor_ident;
            SEL_SUBSYS:
                rd_word[15:0] = state_reg.subsys_ident;
            SEL_FIRST:
                rd_word = state_reg.first_log;
            SEL_NEXT:
                rd_word = state_reg.next_log;
            SEL_SIGEN:
                rd_word = state_reg.sig_enable;
            SEL_IRQ_STAT:
                rd_word[errcfg_pkg::IRQ_W-1:0] = state_reg.irq_status;
            SEL_IRQ_EN:
                rd_word[errcfg_pkg::IRQ_W-1:0] = state_reg.irq_enable;
            default:
                rd_word = '0;
        endcase

        // one wait state: ready rises one cycle into the access phase
        if (rd_prep)
        begin
            state_next.ready  = 1'b1;
            state_next.slverr = (sel == SEL_NONE);
            state_next.rdata  = pwrite ? '0 : rd_word;
        end
        else
        begin
            state_next.ready  = 1'b0;
            state_next.slverr = 1'b0;
            state_next.rdata  = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_reg <= STATE_RESET;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata     = state_reg.rdata;
    assign pready     = state_reg.ready;
    assign pslverr    = state_reg.slverr;
    assign serr_pulse = state_reg.serr;
    assign irq        = state_reg.irq;

endmodule : error_function_config_header

// ===== hw/errcfg_pkg.sv
// constants for the error-reporting function configuration bank
// assumes a 32-bit apb slave with one aligned word per register
package errcfg_pkg;

    // register indices as printed, byte address is four times the index
    localparam logic [7:0] IDX_COMMAND    = 8'h04;
    localparam logic [7:0] IDX_STATUS     = 8'h06;
    localparam logic [7:0] IDX_SUBCLASS   = 8'h0a;
    localparam logic [7:0] IDX_BASECLASS  = 8'h0b;
    localparam logic [7:0] IDX_LATENCY    = 8'h0d;
    localparam logic [7:0] IDX_HEADER     = 8'h0e;
    localparam logic [7:0] IDX_BOARD_VEND = 8'h2c;
    localparam logic [7:0] IDX_BOARD_SUBS = 8'h2e;
    localparam logic [7:0] IDX_FIRST_ERR  = 8'h40;
    localparam logic [7:0] IDX_NEXT_ERR   = 8'h44;
    localparam logic [7:0] IDX_SIG_ENABLE = 8'h48;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h60;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h61;
    localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h62;

    // fixed read values and reset values
    localparam logic [7:0]  SUBCLASS_VAL   = 8'h00;
    localparam logic [7:0]  BASECLASS_VAL  = 8'hff;
    localparam logic [7:0]  LATENCY_VAL    = 8'h00;
    localparam logic [7:0]  HEADER_SINGLE  = 8'h00;
    localparam logic [7:0]  HEADER_MULTI   = 8'h80;
    localparam logic [15:0] IDENT_RESET    = 16'h0000;
    localparam logic [31:0] ERR_LOG_RESET  = 32'h0000_0000;

    // error log bit positions
    localparam int BIT_DRAM     = 18;
    localparam int BIT_PRIMARY  = 17;
    localparam int BIT_SYSBUS   = 16;
    localparam int BIT_FOURTH   = 4;
    localparam int BIT_THIRD    = 3;
    localparam int BIT_SECOND   = 2;
    localparam logic [31:0] ERR_LOG_MASK   = 32'h0007_001c;
    localparam logic [31:0] ERR_GROUP_MASK = 32'h0007_0000;

    // command and status bits
    localparam int BIT_SERR_EN  = 8;
    localparam int BIT_SSE      = 14;

    // interrupt status bits
    localparam int IRQ_W        = 3;
    localparam int IRQ_FIRST    = 0;
    localparam int IRQ_NEXT     = 1;
    localparam int IRQ_SERR     = 2;

endpackage : errcfg_pkg

// ===== verif/error_function_config_header_properties.sv
// port-level checker for the error function configuration bank
// assumes one clock, synchronous active-high reset, bound from the bench
`timescale 1ns/1ps

module error_function_config_header_properties #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire logic              ce,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // events, strap, outputs
    input wire logic              err_dram,
    input wire logic              err_primary_hub_link,
    input wire logic              err_processor_system_bus,
    input wire logic              err_second_hub_link,
    input wire logic              err_third_hub_link,
    input wire logic              err_fourth_hub_link,
    input wire logic              multi_function_strap,
    input wire logic              serr_pulse,
    input wire logic              irq
);
    localparam logic [ADDR_W-1:0] A_SUB  = ADDR_W'(12'h028);
    localparam logic [ADDR_W-1:0] A_BASE = ADDR_W'(12'h02c);
    localparam logic [ADDR_W-1:0] A_LAT  = ADDR_W'(12'h034);
    localparam logic [ADDR_W-1:0] A_HDR  = ADDR_W'(12'h038);
    logic                         rd;
    logic                         err_any;

    assign rd      = pready && !pwrite;
    assign err_any = err_dram | err_primary_hub_link
                   | err_processor_system_bus | err_second_hub_link
                   | err_third_hub_link | err_fourth_hub_link;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    a_ready_follows: assert property (psel && penable && !pready && ce
        |=> pready) else $error("no ready after access phase");
    a_ready_single: assert property (pready && ce |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access phase");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_error_reply: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error reply malformed");
    a_subclass_fixed: assert property (rd && paddr == A_SUB
        |-> prdata == 32'h0) else $error("subclass not zero");
    a_base_class: assert property (rd && paddr == A_BASE
        |-> prdata == 32'h0000_00ff) else $error("base class wrong");
    a_latency_zero: assert property (rd && paddr == A_LAT
        |-> prdata == 32'h0) else $error("latency word not zero");
    a_header_strap: assert property (rd && paddr == A_HDR
        |-> prdata == {24'h0, $past(multi_function_strap, 2), 7'h0})
        else $error("header value wrong");
    a_serr_cause: assert property (serr_pulse |-> $past(err_any))
        else $error("serr without error event");
    a_reset_quiet: assert property (disable iff (1'b0) reset && ce
        |=> !pready && !serr_pulse && !irq)
        else $error("outputs active after reset");

    c_serr: cover property (serr_pulse);
    c_slverr: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_header: cover property (rd && paddr == A_HDR && multi_function_strap);
endmodule : error_function_config_header_properties

// ===== verif/error_function_config_header_bench.sv
// self-checking bench for the error function configuration bank
// assumes the checker module is compiled beforehand
`timescale 1ns/1ps

module error_function_config_header_bench;
    localparam logic [11:0] A_CMD = 12'h010, A_STS = 12'h018;
    localparam logic [11:0] A_SUB = 12'h028, A_BASE = 12'h02c;
    localparam logic [11:0] A_LAT = 12'h034, A_HDR = 12'h038;
    localparam logic [11:0] A_VEND = 12'h0b0, A_SUBS = 12'h0b8;
    localparam logic [11:0] A_FIRST = 12'h100, A_NEXT = 12'h110;
    localparam logic [11:0] A_EN = 12'h120, A_IEN = 12'h184;
    localparam logic [11:0] A_ICL = 12'h188;
    logic        clk_sys, reset, warm_reset, ce, psel, penable, pwrite;
    logic [11:0] paddr, a;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, se, multi_function_strap;
    logic        serr_pulse, irq;
    logic [5:0]  err;
    logic [31:0] lbit [6] = '{32'h4, 32'h8, 32'h10, 32'h1_0000,
                              32'h2_0000, 32'h4_0000};
    int          err_count, cmp_count, serr_count, cyc, n;

    error_function_config_header #(.ADDR_W(12)) dut (
        .clk_sys(clk_sys), .reset(reset), .warm_reset(warm_reset),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .err_dram(err[5]), .err_primary_hub_link(err[4]),
        .err_processor_system_bus(err[3]),
        .err_fourth_hub_link(err[2]), .err_third_hub_link(err[1]),
        .err_second_hub_link(err[0]),
        .multi_function_strap(multi_function_strap),
        .serr_pulse(serr_pulse), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (serr_pulse === 1'b1)
            serr_count++;
        if (cyc == 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: %s got %h", $time, what, got);
            err_count++;
        end
    endtask : check

    // setup, access, hold until ready sampled high
    task automatic apb(input logic wr, input logic [11:0] ad,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp,
                         input string what);
        apb(1'b0, ad, 32'h0);
        check(rd, exp, what);
    endtask : rdchk

    task automatic pulse(input logic [5:0] m);
        @(posedge clk_sys);
        err <= m;
        @(posedge clk_sys);
        err <= 6'h00;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reset, ce} = 2'b11;
        {warm_reset, psel, penable, pwrite, multi_function_strap} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err = 6'h00;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rdchk(A_SUB, 32'h0, "subclass");
        apb(1'b1, A_SUB, 32'hffff_ffff);
        rdchk(A_SUB, 32'h0, "subclass after write");
        rdchk(A_BASE, 32'h0000_00ff, "base class");
        rdchk(A_LAT, 32'h0, "latency");
        rdchk(A_HDR, 32'h0, "header single");
        multi_function_strap <= 1'b1;
        rdchk(A_HDR, 32'h0000_0080, "header multi");
        rdchk(12'h3fc, 32'h0, "unmapped read");
        check({31'h0, se}, 32'h1, "unmapped error");
        $display("fixed words done");
        for (int i = 0; i < 2; i++)
        begin
            a = i ? A_SUBS : A_VEND;
            rdchk(a, 32'h0, "ident reset");
            apb(1'b1, a, 32'h1234_abcd);
            apb(1'b1, a, 32'h0000_5555);
            rdchk(a, 32'h0000_abcd, "ident locked");
        end
        $display("identifiers done");
        apb(1'b1, A_EN, 32'h0007_001c);
        apb(1'b1, A_CMD, 32'h0000_0100);
        apb(1'b1, A_IEN, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            n = serr_count;
            pulse(6'h01 << i);
            rdchk(A_FIRST, lbit[i], "first log bit");
            check(32'(serr_count), 32'(n + 1), "serr count");
            check({31'h0, irq}, 32'h1, "irq raised");
            apb(1'b1, A_FIRST, 32'h0);
            rdchk(A_FIRST, lbit[i], "zero write kept");
            apb(1'b1, A_FIRST, lbit[i]);
            rdchk(A_FIRST, 32'h0, "flag cleared");
            apb(1'b1, A_ICL, 32'h7);
            @(posedge clk_sys);
            check({31'h0, irq}, 32'h0, "irq cleared");
        end
        $display("log bits done");
        pulse(6'h20);
        pulse(6'h11);
        rdchk(A_FIRST, 32'h0004_0000, "first kept");
        rdchk(A_NEXT, 32'h4, "next log");
        pulse(6'h2c);
        rdchk(A_NEXT, 32'h14, "next blocked");
        apb(1'b1, A_IEN, 32'h0);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, A_IEN, 32'h1);
        @(posedge clk_sys);
        check({31'h0, irq}, 32'h1, "irq unmasked");
        apb(1'b1, A_FIRST, 32'h0004_0000);
        apb(1'b1, A_NEXT, 32'h14);
        rdchk(A_STS, 32'h4000, "serr flag");
        apb(1'b1, A_STS, 32'h4000);
        rdchk(A_STS, 32'h0, "serr flag cleared");
        $display("next log done");
        apb(1'b1, A_CMD, 32'h0);
        n = serr_count;
        pulse(6'h04);
        rdchk(A_FIRST, 32'h10, "flag without serr");
        check(32'(serr_count), 32'(n), "serr disabled");
        rdchk(A_STS, 32'h0, "no serr flag");
        // an error while the clock enable is low must not be logged
        ce <= 1'b0;
        pulse(6'h01);
        ce <= 1'b1;
        rdchk(A_NEXT, 32'h0, "ce freezes next log");
        apb(1'b1, A_CMD, 32'h0000_0100);
        @(posedge clk_sys);
        warm_reset <= 1'b1;
        @(posedge clk_sys);
        warm_reset <= 1'b0;
        rdchk(A_FIRST, 32'h10, "warm keeps log");
        rdchk(A_CMD, 32'h0, "warm clears command");
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rdchk(A_FIRST, 32'h0, "cold clears log");
        rdchk(A_VEND, 32'h0, "cold clears ident");
        $display("resets done");
        report_and_stop();
    end
endmodule : error_function_config_header_bench

bind error_function_config_header error_function_config_header_properties
    #(.ADDR_W(ADDR_W)) u_props (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_dram(err_dram), .err_primary_hub_link(err_primary_hub_link),
    .err_processor_system_bus(err_processor_system_bus),
    .err_second_hub_link(err_second_hub_link),
    .err_third_hub_link(err_third_hub_link),
    .err_fourth_hub_link(err_fourth_hub_link),
    .multi_function_strap(multi_function_strap),
    .serr_pulse(serr_pulse), .irq(irq));
